// file: rtl/hbar_params.svh
/*
  Constants for the host bus arbitration and processor reset block.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef HBAR_PARAMS_SVH
`define HBAR_PARAMS_SVH

// Host clock period in picoseconds (200 MHz).
`define HBAR_CLK_PERIOD_PS 5000
// Processor reset stretch after the system reset input releases, in microseconds.
`define HBAR_CPU_RST_US 1000
// Stretch length in host clocks, derived from the time and the clock rate.
`define HBAR_CPU_RST_CYC ((`HBAR_CPU_RST_US * 1000000) / `HBAR_CLK_PERIOD_PS)
// Least set-up of the strap before the reset release edge, in host clocks.
`define HBAR_STRAP_SETUP_CYC 4
// Hold of the strap after the release edge: least and most, in host clocks.
`define HBAR_STRAP_HOLD_MIN 2
`define HBAR_STRAP_HOLD_MAX 20
// Hold actually used: inside the legal window with margin on both sides.
`define HBAR_STRAP_HOLD_CYC 4
// Width of the reset stretch counter.
`define HBAR_RST_CNT_W 20
// Width of the strap hold counter.
`define HBAR_HOLD_CNT_W 5
// Width of the pending-request counter.
`define HBAR_PEND_W 4
// Largest request pipeline depth allowed before new requests are blocked.
`define HBAR_PIPE_LIMIT 4'h8

`endif

// file: rtl/hbar_pkg.sv
/*
  Types for the host bus arbitration and processor reset block.
  Assumes the constants header is on the include path.
*/
package hbar_pkg;
  `include "hbar_params.svh"

  // Reset sequencer states.
  typedef enum logic [1:0] {
    HBAR_RST_HOLD = 2'b00,
    HBAR_RST_STRETCH = 2'b01,
    HBAR_RST_STRAP = 2'b10,
    HBAR_RST_RUN = 2'b11
  } hbar_rst_e;
endpackage : hbar_pkg

// file: rtl/hbar_host_bus.sv
/*
  Host bus agent logic of the hub: request strobe, block-next-request flow control,
  priority bus request, data-busy, defer, processor reset and the bus request strap.
  Assumes open-drain pads outside that turn the output enables into wire levels,
  and core logic on mclk that raises snoop, defer and data requests.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hbar_params.svh"

// Notes on behaviour
// [R1] Any bus owner, the hub too, strobes the first of the two cycles of a request phase.
// [R2] The hub asserts block-next-request to stop the owner issuing, limiting pipeline depth.
// [R3] As sole priority agent the hub asserts priority request when it needs the address bus.
// [R4] Priority request outranks symmetric ones; the symmetric owner stops unless it holds lock.
// [R5] The hub drives bus request zero low in processor reset; it is sampled at the release.
// [R6] Bus request zero is low at least 4 clocks before the release and 2 to 20 clocks after it.
// [R7] After the hold the hub stops driving bus request zero.
// [R8] Processor reset follows the system reset input and is stretched about 1 ms past its release.
// [R9] The data bus owner asserts data-busy to keep the bus for multi-cycle transfers.
// [R10] The hub asserts defer when it will end a snoop with a deferred or retry response.
// [R11] The hub drops the priority request once its pending requests have been issued.
module hbar_host_bus
  import hbar_pkg::*;
#(
  parameter int unsigned RST_CYC = `HBAR_CPU_RST_CYC // Reset stretch, shorten in simulation.
) (
  input wire logic mclk, // Host clock, 200 MHz.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes all state while low.
  input wire logic system_reset_in_n, // System reset pin, active low, asynchronous.
  input wire logic hub_req_pending, // Core has snoop or interrupt requests to issue.
  input wire logic hub_req_go, // Core issues one request now (needs ownership).
  input wire logic hub_data_multi, // Hub owns data bus for a multi-cycle transfer.
  input wire logic hub_defer, // Hub will defer or retry the snooped transaction.
  input wire logic req_strobe_in_n, // Request strobe seen on the bus, active low.
  input wire logic req_retire, // Core retires one outstanding bus request.
  input wire logic bus_lock_in_n, // Bus lock seen on the bus, active low.
  output logic request_strobe_out_n, // Request strobe drive level.
  output logic request_strobe_oe, // Request strobe output enable.
  output logic block_next_request_out_n, // Block-next-request drive level.
  output logic block_next_request_oe, // Block-next-request output enable.
  output logic priority_bus_request_n, // Priority bus request, active low.
  output logic bus_request_zero_out_n, // Bus request zero drive level.
  output logic bus_request_zero_oe, // Bus request zero output enable.
  output logic processor_reset_n, // Processor reset, active low.
  output logic data_busy_out_n, // Data-busy drive level.
  output logic data_busy_oe, // Data-busy output enable.
  output logic defer_response_n, // Defer, active low.
  output logic hub_granted // Hub may issue requests this cycle.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Synchroniser state: three stages, a change counts once stages two and three agree.
  logic [2:0] rst_sync;
  logic rst_in_n;
  logic [2:0] next_rst_sync;
  logic next_rst_in_n;

  // Reset sequencer state.
  hbar_rst_e rst_state;
  hbar_rst_e next_rst_state;
  logic [`HBAR_RST_CNT_W-1:0] rst_cnt;
  logic [`HBAR_RST_CNT_W-1:0] next_rst_cnt;
  logic next_processor_reset_n;
  logic next_breq_oe;

  // Bus side state.
  logic [`HBAR_PEND_W-1:0] pend;
  logic [`HBAR_PEND_W-1:0] next_pend;
  logic next_strobe_oe;
  logic next_bnr_oe;
  logic next_prio_n;
  logic next_dbsy_oe;
  logic next_defer_n;
  logic next_granted;
  logic lock_seen;

  ////////////////////////////////////////////////////////////////////////////////
  // The system reset pin is filtered; only agreeing late stages move the level.
  always_comb
  begin
    next_rst_sync = {rst_sync[1:0], system_reset_in_n};
    next_rst_in_n = rst_in_n;
    if (rst_sync[1] == rst_sync[2])
    begin
      next_rst_in_n = rst_sync[2];
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_sync <= 3'h0;
      rst_in_n <= 1'b0;
    end
    else if (clk_en)
    begin
      rst_sync <= next_rst_sync;
      rst_in_n <= next_rst_in_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Processor reset sequencer. The strap is driven low throughout reset, so the
  // set-up before the release is the full stretch, far above the 4-clock minimum.
  always_comb
  begin
    next_rst_state = rst_state;
    next_rst_cnt = rst_cnt;
    next_processor_reset_n = 1'b0;
    next_breq_oe = 1'b1; // [R5]
    unique case (rst_state)
      HBAR_RST_HOLD:
      begin
        next_rst_cnt = '0;
        if (rst_in_n)
        begin
          next_rst_state = HBAR_RST_STRETCH;
        end
      end
      HBAR_RST_STRETCH:
      begin
        next_rst_cnt = rst_cnt + 1'b1; // [R8]
        if (!rst_in_n)
        begin
          next_rst_state = HBAR_RST_HOLD;
        end
        else if (rst_cnt >= RST_CYC[`HBAR_RST_CNT_W-1:0] - 1'b1)
        begin
          next_rst_state = HBAR_RST_STRAP;
          next_rst_cnt = '0;
          next_processor_reset_n = 1'b1; // [R8]
        end
      end
      HBAR_RST_STRAP:
      begin
        next_processor_reset_n = 1'b1;
        next_rst_cnt = rst_cnt + 1'b1; // [R6]
        if (!rst_in_n)
        begin
          next_rst_state = HBAR_RST_HOLD;
          next_processor_reset_n = 1'b0;
        end
        else if (rst_cnt >= `HBAR_RST_CNT_W'(`HBAR_STRAP_HOLD_CYC - 1))
        begin
          next_rst_state = HBAR_RST_RUN;
          next_breq_oe = 1'b0; // [R7]
        end
      end
      HBAR_RST_RUN:
      begin
        next_processor_reset_n = rst_in_n;
        next_breq_oe = ~rst_in_n;
        if (!rst_in_n)
        begin
          next_rst_state = HBAR_RST_HOLD;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_state <= HBAR_RST_HOLD;
      rst_cnt <= '0;
      processor_reset_n <= 1'b0;
      bus_request_zero_oe <= 1'b1;
    end
    else if (clk_en)
    begin
      rst_state <= next_rst_state;
      rst_cnt <= next_rst_cnt;
      processor_reset_n <= next_processor_reset_n;
      bus_request_zero_oe <= next_breq_oe;
    end
  end

  // The strap level is always low; only its enable moves.
  assign bus_request_zero_out_n = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus side: priority request, strobe, pipeline blocking, data-busy and defer.
  // Bus inputs share mclk (common-clock bus), so no synchroniser is needed.
  assign lock_seen = ~bus_lock_in_n;

  always_comb
  begin
    next_pend = pend;
    if (!req_strobe_in_n && !(req_retire && pend != '0))
    begin
      next_pend = (pend == '1) ? pend : pend + 1'b1;
    end
    else if (req_strobe_in_n && req_retire && pend != '0)
    begin
      next_pend = pend - 1'b1;
    end
    next_prio_n = ~(hub_req_pending && processor_reset_n); // [R3] [R11]
    // Ownership only once priority is asserted and no locked sequence runs.
    next_granted = !priority_bus_request_n && !lock_seen && hub_req_pending; // [R4]
    // The cycle after a strobe is the second request cycle, so a held go waits one cycle.
    next_strobe_oe = hub_req_go && hub_granted && !request_strobe_oe; // [R1]
    next_bnr_oe = processor_reset_n && (pend >= `HBAR_PIPE_LIMIT); // [R2]
    next_dbsy_oe = hub_data_multi && processor_reset_n; // [R9]
    next_defer_n = ~(hub_defer && processor_reset_n); // [R10]
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend <= '0;
      priority_bus_request_n <= 1'b1;
      hub_granted <= 1'b0;
      request_strobe_oe <= 1'b0;
      block_next_request_oe <= 1'b0;
      data_busy_oe <= 1'b0;
      defer_response_n <= 1'b1;
    end
    else if (clk_en)
    begin
      pend <= next_pend;
      priority_bus_request_n <= next_prio_n;
      hub_granted <= next_granted;
      request_strobe_oe <= next_strobe_oe;
      block_next_request_oe <= next_bnr_oe;
      data_busy_oe <= next_dbsy_oe;
      defer_response_n <= next_defer_n;
    end
  end

  // Open-drain style pins drive only low.
  assign request_strobe_out_n = 1'b0;
  assign block_next_request_out_n = 1'b0;
  assign data_busy_out_n = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_strap_during_reset;
    @(posedge mclk) disable iff (!rst_b)
      !processor_reset_n |-> bus_request_zero_oe;
  endproperty
  a_strap_during_reset: assert property (p_strap_during_reset) // [R5]
    else $error("strap not driven during processor reset");

  property p_strap_hold;
    @(posedge mclk) disable iff (!rst_b)
      (clk_en && $rose(processor_reset_n)) |-> bus_request_zero_oe[*2];
  endproperty
  a_strap_hold: assert property (p_strap_hold) // [R6]
    else $error("strap released too soon after reset");

  property p_strap_release;
    @(posedge mclk) disable iff (!rst_b)
      (rst_state == HBAR_RST_RUN && rst_in_n) |-> !bus_request_zero_oe;
  endproperty
  a_strap_release: assert property (p_strap_release) // [R7]
    else $error("strap still driven after hold");

  property p_reset_follows;
    @(posedge mclk) disable iff (!rst_b)
      (clk_en && !rst_in_n) |=> !processor_reset_n;
  endproperty
  a_reset_follows: assert property (p_reset_follows) // [R8]
    else $error("processor reset not asserted with system reset");

  property p_strobe_one;
    @(posedge mclk) disable iff (!rst_b)
      (clk_en && request_strobe_oe) |=> !request_strobe_oe;
  endproperty
  a_strobe_one: assert property (p_strobe_one) // [R1]
    else $error("request strobe held two cycles");

  property p_block;
    @(posedge mclk) disable iff (!rst_b)
      (clk_en && processor_reset_n && pend >= `HBAR_PIPE_LIMIT) |=> block_next_request_oe;
  endproperty
  a_block: assert property (p_block) // [R2]
    else $error("pipeline full but not blocked");

  property p_prio;
    @(posedge mclk) disable iff (!rst_b)
      (clk_en && hub_req_pending && processor_reset_n) |=> !priority_bus_request_n;
  endproperty
  a_prio: assert property (p_prio) // [R3]
    else $error("priority request missing");

  property p_prio_drop;
    @(posedge mclk) disable iff (!rst_b)
      (clk_en && !hub_req_pending) |=> priority_bus_request_n;
  endproperty
  a_prio_drop: assert property (p_prio_drop) // [R11]
    else $error("priority request held without pending work");

  property p_lock;
    @(posedge mclk) disable iff (!rst_b)
      (clk_en && lock_seen) |=> !hub_granted;
  endproperty
  a_lock: assert property (p_lock) // [R4]
    else $error("granted during locked sequence");

  property p_dbsy;
    @(posedge mclk) disable iff (!rst_b)
      (clk_en && hub_data_multi && processor_reset_n) |=> data_busy_oe;
  endproperty
  a_dbsy: assert property (p_dbsy) // [R9]
    else $error("data busy missing");

  property p_defer;
    @(posedge mclk) disable iff (!rst_b)
      (clk_en && hub_defer && processor_reset_n) |=> !defer_response_n;
  endproperty
  a_defer: assert property (p_defer) // [R10]
    else $error("defer missing");

endmodule : hbar_host_bus
`default_nettype wire

// file: bench/hbar_cpu_model.sv
/*
  Processor model for the far side of the host bus block.
  Assumes the bench resolves open-drain wire levels and feeds them in.
*/
`timescale 1ns/1ps
`default_nettype none
module hbar_cpu_model (
  input wire logic mclk, // Host clock.
  input wire logic processor_reset_n, // Reset from the hub.
  input wire logic bus_request_zero_n, // Strap wire level.
  input wire logic priority_bus_request_n, // Hub priority request.
  input wire logic block_next_request_n, // Block wire level.
  input wire logic issue_en, // Bench lets the model issue requests.
  input wire logic lock_en, // Bench asks for a locked sequence.
  output logic req_strobe_n = 1'b1, // Strobe drive, low to request.
  output logic bus_lock_n = 1'b1, // Bus lock, active low.
  output logic strap_seen // Strap level taken at reset release.
);
  // One strobe cycle then one quiet cycle; a locked owner ignores the priority request.
  always @(posedge mclk)
  begin
    bus_lock_n <= !lock_en;
    if (issue_en && processor_reset_n && block_next_request_n && req_strobe_n &&
        (priority_bus_request_n || !bus_lock_n))
      req_strobe_n <= 1'b0;
    else
      req_strobe_n <= 1'b1;
  end

  // The strap is only meaningful on the release edge of processor reset.
  always @(posedge processor_reset_n)
    strap_seen = bus_request_zero_n;
endmodule : hbar_cpu_model
`default_nettype wire

// file: bench/tb.sv
/*
  Self-checking bench for the host bus block with a processor model.
  Assumes the design and the model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hbar_pkg::*;
  localparam int unsigned RST_N = 20;
  logic mclk, rst_b, clk_en, sys_n, pend, go, multi, dfr, retire, issue, lock;
  logic stb_o, stb_oe, blk_o, blk_oe, prio_n, strap_o, strap_oe, cpu_rst_n;
  logic busy_o, busy_oe, defer_n, granted, cpu_stb_n, lock_n, strap_seen;
  logic stb_w, blk_w, strap_w, busy_w;
  logic [7:0] seed;
  int fails, tests_run, cyc, n;

  // Open-drain wires with pull-ups, since the simulator would otherwise pick a level.
  assign stb_w = cpu_stb_n & !(stb_oe & !stb_o);
  assign blk_w = blk_oe ? blk_o : 1'b1;
  assign strap_w = strap_oe ? strap_o : 1'b1;
  assign busy_w = busy_oe ? busy_o : 1'b1;

  hbar_host_bus #(.RST_CYC(RST_N)) i_dut (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
    .system_reset_in_n(sys_n), .hub_req_pending(pend), .hub_req_go(go),
    .hub_data_multi(multi), .hub_defer(dfr), .req_strobe_in_n(stb_w), .req_retire(retire),
    .bus_lock_in_n(lock_n), .request_strobe_out_n(stb_o), .request_strobe_oe(stb_oe),
    .block_next_request_out_n(blk_o), .block_next_request_oe(blk_oe),
    .priority_bus_request_n(prio_n), .bus_request_zero_out_n(strap_o),
    .bus_request_zero_oe(strap_oe), .processor_reset_n(cpu_rst_n), .data_busy_out_n(busy_o),
    .data_busy_oe(busy_oe), .defer_response_n(defer_n), .hub_granted(granted));

  hbar_cpu_model i_cpu (.mclk(mclk), .processor_reset_n(cpu_rst_n), .bus_request_zero_n(strap_w),
    .priority_bus_request_n(prio_n), .block_next_request_n(blk_w), .issue_en(issue),
    .lock_en(lock), .req_strobe_n(cpu_stb_n), .bus_lock_n(lock_n), .strap_seen(strap_seen));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard.
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // Active-low outputs answer an active-high request.
  function automatic logic exp_low(input logic req);
    return !req;
  endfunction : exp_low

  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : step

  task automatic check_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : check_bit

  task automatic check_cnt(input int got, input int lo, input int hi, input string what);
    tests_run++;
    if (got < lo || got > hi)
    begin
      fails++;
      $display("unexpected at %0t: %s count %0d", $time, what, got);
    end
  endtask : check_cnt

  // Release the system reset and time the stretch and the strap hold.
  task automatic release_sys;
    sys_n = 1'b1;
    n = 0;
    while (cpu_rst_n !== 1'b1 && n < 100)
    begin
      check_bit(strap_w, 1'b0, "strap not low before release");
      step(1);
      n++;
    end
    check_cnt(n, RST_N, RST_N + 5, "reset stretch");
    check_bit(strap_seen, 1'b0, "strap level at release");
    n = 0;
    while (strap_oe === 1'b1 && n < 40)
    begin
      step(1);
      n++;
    end
    check_cnt(n, 2, 20, "strap hold");
    step(2);
    check_bit(strap_oe, 1'b0, "strap still driven");
  endtask : release_sys

  task automatic final_report;
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    {rst_b, sys_n, pend, go, multi, dfr, retire, issue, lock} = '0;
    clk_en = 1'b1;
    seed = 8'h13;
    step(3);
    rst_b = 1'b1;
    step(4);
    release_sys();
    $display("test reset sequence done");
    // Random defer and data-busy requests, each answered one cycle later.
    repeat (40)
    begin
      seed = lfsr(seed);
      {multi, dfr} = seed[1:0];
      step(1);
      check_bit(defer_n, exp_low(dfr), "defer");
      check_bit(busy_oe, multi, "data busy");
      check_bit(busy_w, exp_low(multi), "data busy wire");
    end
    {multi, dfr} = 2'b00;
    step(1);
    // A frozen clock enable must hold a new defer request back until it runs again.
    clk_en = 1'b0;
    dfr = 1'b1;
    step(3);
    check_bit(defer_n, 1'b1, "defer while frozen");
    clk_en = 1'b1;
    step(1);
    check_bit(defer_n, 1'b0, "defer after thaw");
    dfr = 1'b0;
    $display("test defer and data busy done");
    pend = 1'b1;
    step(1);
    check_bit(prio_n, 1'b0, "priority request");
    n = 0;
    while (granted !== 1'b1 && n < 10)
    begin
      step(1);
      n++;
    end
    // Go held two cycles: the second cycle of the request phase takes no new strobe.
    go = 1'b1;
    step(1);
    check_bit(stb_w, 1'b0, "hub strobe");
    step(1);
    go = 1'b0;
    check_bit(stb_oe, 1'b0, "strobe one cycle");
    pend = 1'b0;
    step(1);
    check_bit(prio_n, 1'b1, "priority release");
    $display("test priority request done");
    // A locked owner keeps the bus; the hub gets no grant meanwhile.
    {lock, pend, issue} = 3'b111;
    step(3);
    repeat (4)
    begin
      check_bit(granted, 1'b0, "grant under lock");
      step(1);
    end
    {lock, issue} = 2'b00;
    step(3);
    check_bit(granted, 1'b1, "grant after lock");
    pend = 1'b0;
    retire = 1'b1;
    step(20);
    retire = 1'b0;
    $display("test lock done");
    // Fill the request pipeline until the hub blocks, then retire two.
    issue = 1'b1;
    n = 0;
    while (blk_oe !== 1'b1 && n < 40)
    begin
      step(1);
      n = n + int'(!stb_w);
    end
    check_cnt(n, 8, 9, "requests before block");
    issue = 1'b0;
    step(3);
    check_bit(blk_w, 1'b0, "block holds");
    retire = 1'b1;
    step(2);
    retire = 1'b0;
    step(2);
    check_bit(blk_oe, 1'b0, "block release");
    $display("test block next request done");
    sys_n = 1'b0;
    step(6);
    check_bit(cpu_rst_n, 1'b0, "reset follows input");
    check_bit(strap_w, 1'b0, "strap in reset");
    release_sys();
    $display("test second system reset done");
    final_report();
  end
endmodule : tb
`default_nettype wire
